// ### dv/adt_core_model.sv
// Behavioural model of the observed core bus, one beat per request.
`timescale 1ns/1ns
module adt_core_model (
  // Clock.
  input wire logic mclk,
  // Observed channels.
  output logic [49:0] observed_write_addr_signals,
  output logic [47:0] observed_awaddr,
  output logic [49:0] observed_read_addr_signals,
  output logic [47:0] observed_araddr,
  output logic [34:0] observed_write_data_signals,
  output logic [19:0] observed_write_resp_signals,
  // Read data matcher.
  output logic read_data_cond_met,
  output logic [15:0] read_data_cond_id
);
  logic req = 1'b0;
  logic [15:0] cnt = 16'h0;
  logic [63:0] pat;
  logic [49:0] aw_n;
  logic [49:0] ar_n;
  logic [47:0] ad_n;
  logic [34:0] w_n;
  logic [19:0] b_n;
  logic met_n;
  assign pat = {4{cnt}};
  initial begin
    {observed_write_addr_signals, observed_awaddr} = '0;
    {observed_read_addr_signals, observed_araddr} = '0;
    {observed_write_data_signals, observed_write_resp_signals} = '0;
    {read_data_cond_met, read_data_cond_id} = '0;
  end
  always @(posedge mclk) begin
    cnt <= cnt + 16'h1;
    if (req) begin
      req <= 1'b0;
      observed_write_addr_signals <= aw_n;
      observed_read_addr_signals <= ar_n;
      {observed_awaddr, observed_araddr} <= {ad_n, ad_n};
      observed_write_data_signals <= w_n;
      observed_write_resp_signals <= b_n;
      read_data_cond_met <= met_n;
      read_data_cond_id <= ar_n[15:0];
    end else begin
      // Between beats valid flags are low and all else keeps moving.
      observed_write_addr_signals <= pat[49:0] & ~(50'h3 << 48);
      observed_read_addr_signals <= pat[49:0] & ~(50'h3 << 48);
      {observed_awaddr, observed_araddr} <= {pat[47:0], ~pat[47:0]};
      observed_write_data_signals <= pat[34:0] & ~(35'h3 << 33);
      observed_write_resp_signals <= pat[19:0] & ~(20'h3 << 18);
      read_data_cond_met <= cnt[0];
      read_data_cond_id <= ~cnt;
    end
  end
  task automatic beat(input logic [49:0] aw, input logic [49:0] ar,
      input logic [47:0] ad, input logic [34:0] w, input logic [19:0] b,
      input logic met);
    {aw_n, ar_n, ad_n, w_n, b_n, met_n} = {aw, ar, ad, w, b, met};
    req <= 1'b1;
    @(posedge mclk);
    @(posedge mclk);
  endtask
endmodule

// ### dv/adt_trigger_bench.sv
// Self-checking bench for the bus debug trigger.
`timescale 1ns/1ns
module adt_trigger_bench;
  import adt_pkg::*;
  localparam logic [63:0] EN = 64'h1 << 63;
  localparam logic [63:0] PR = 64'h1 << 62;
  localparam logic [49:0] AWV = 50'h1_0000_0000_1234;
  localparam logic [49:0] ARV = 50'h1_0040_0000_0077;
  localparam logic [47:0] ADR = 48'hABC0_0000_1000;
  localparam int NONE = 260;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [31:0] reg_addr = 32'h0;
  logic [63:0] reg_wdata = 64'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [63:0] reg_rdata;
  logic [49:0] observed_write_addr_signals, observed_read_addr_signals;
  logic [47:0] observed_awaddr, observed_araddr;
  logic [34:0] observed_write_data_signals;
  logic [19:0] observed_write_resp_signals;
  logic read_data_cond_met;
  logic [15:0] read_data_cond_id;
  logic [7:0] ext_trigger_event = 8'h00;
  logic trigger_out, trigger_fired;
  int fail_count = 0;
  int cmp_count = 0;
  int k;
  int dl [5] = '{0, 1, 2, 3, 255};
  adt_trigger u_dut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .observed_write_addr_signals, .observed_awaddr,
    .observed_read_addr_signals, .observed_araddr,
    .observed_write_data_signals, .observed_write_resp_signals,
    .read_data_cond_met, .read_data_cond_id, .ext_trigger_event,
    .trigger_out, .trigger_fired);
  adt_core_model u_core (.mclk, .observed_write_addr_signals,
    .observed_awaddr, .observed_read_addr_signals, .observed_araddr,
    .observed_write_data_signals, .observed_write_resp_signals,
    .read_data_cond_met, .read_data_cond_id);
  initial begin
    forever #20 mclk = ~mclk;
  end
  task automatic check(input string nm, input logic [63:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [31:0] addr_of(input int i);
    if (i == 17) return ADT_ADDR_SWTRIG;
    if (i == 18) return 32'h3FF01600;
    if (i == 19) return ADT_ADDR_STATUS;
    return ADT_REG_ADDR[i];
  endfunction
  task automatic do_reset();
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input int i, input logic [63:0] d);
    reg_addr <= addr_of(i);
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input int i, input logic [63:0] exp);
    reg_addr <= addr_of(i);
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    check("reg_rdata", reg_rdata, exp);
    @(posedge mclk);
  endtask
  // Counts cycles to the trigger pulse; NONE means it never came.
  task automatic trig(input int exp);
    k = 0;
    @(negedge mclk);
    while (trigger_out !== 1'b1 && k < NONE) begin
      @(negedge mclk);
      k++;
    end
    if (exp >= 0) check("trigger_lat", 64'(k), 64'(exp));
    if (k < NONE) begin
      @(negedge mclk);
      check("trigger_len", {63'h0, trigger_out}, 64'h0);
      check("trigger_fired", {63'h0, trigger_fired}, 64'h1);
    end
    @(posedge mclk);
  endtask
  task automatic hit(input logic [49:0] aw, ar, input logic [47:0] ad,
      input logic [34:0] w, input logic [19:0] b, input logic met,
      input int exp);
    u_core.beat(aw, ar, ad, w, b, met);
    trig(exp);
  endtask
  initial begin
    #1000000;
    fail_count++;
    final_report();
  end
  initial begin
    do_reset();
    for (int i = 0; i < ADT_NREG; i++) begin
      rd(i, 64'h0);
      wr(i, 64'h5A00 | 64'(i));
      rd(i, 64'h5A00 | 64'(i));
    end
    rd(17, 64'h0);
    wr(18, '1);
    rd(18, 64'h0);
    foreach (dl[j]) begin
      do_reset();
      wr(0, 64'(dl[j]));
      wr(17, 64'hFFFF_0000_1234_5678);
      trig(dl[j] == 0 ? NONE : dl[j] == 1 ? 0 : dl[j] + 1);
    end
    rd(19, 64'h2);
    wr(19, 64'h0);
    rd(19, 64'h0);
    check("fired_clear", {63'h0, trigger_fired}, 64'h0);
    do_reset();
    wr(0, 64'h0801);
    ext_trigger_event <= 8'hF7;
    @(posedge mclk);
    ext_trigger_event <= 8'h00;
    trig(NONE);
    ext_trigger_event <= 8'h08;
    @(posedge mclk);
    ext_trigger_event <= 8'h00;
    trig(-1);
    check("ext_lat", {63'h0, k < 5}, 64'h1);
    do_reset();
    wr(0, 64'h1);
    wr(1, 64'(AWV));
    wr(2, 64'h0001_0000_0000_FFFF);
    wr(3, 64'(ADR));
    wr(4, 64'h0000_FFFF_FFFF_FFFF);
    hit(AWV, 0, ADR, 0, 0, 0, NONE);
    wr(2, EN | 64'h0001_0000_0000_FFFF);
    hit(AWV, 0, ADR ^ 48'h1, 0, 0, 0, NONE);
    hit(AWV ^ 50'h1, 0, ADR, 0, 0, 0, NONE);
    hit(AWV | (50'hF << 16), 0, ADR, 0, 0, 0, 0);
    wr(0, 64'h3);
    hit(AWV, 0, ADR, 0, 0, 0, 4);
    wr(0, 64'h1);
    wr(10, 64'h0);
    wr(2, EN | PR | 64'h0001_0000_0000_FFFF);
    hit(AWV, 0, ADR, 35'h2_0000_1235, 0, 0, NONE);
    hit(AWV, 0, ADR, 35'h2_0000_1234, 0, 0, 0);
    do_reset();
    wr(0, 64'h1);
    wr(5, 64'(ARV));
    wr(6, EN | PR | 64'h0001_FFC0_0000_FFFF);
    wr(7, 64'(ADR));
    wr(8, 64'h0000_FFFF_FFFF_FFFF);
    hit(0, ARV, ADR, 0, 0, 0, NONE);
    hit(0, ARV, ADR, 0, 0, 1, 0);
    do_reset();
    wr(0, 64'h1);
    wr(9, 64'h0000_0003_00F0_0000);
    wr(10, EN | 64'h0000_0003_FFFF_0000);
    wr(13, 64'h0042);
    wr(14, 64'hFFFF);
    hit(0, 0, ADR, 35'h3_00F0_0042, 0, 0, 0);
    hit(0, 0, ADR, 35'h3_00F0_0043, 0, 0, NONE);
    wr(15, 64'h6_0000);
    wr(16, EN | 64'hF_0000);
    hit(0, 0, ADR, 0, 20'h5_0000, 0, NONE);
    hit(0, 0, ADR, 0, 20'h6_0000, 0, 0);
    final_report();
  end
endmodule

// ### include/adt_pkg.sv
// Register map, field layout and state encoding of the bus debug trigger.
package adt_pkg;
  localparam int ADT_DW = 64;
  localparam int ADT_AW = 32;
  localparam int ADT_NREG = 17;
  localparam int ADT_IXW = 5;

  // Storage register indices.
  localparam logic [ADT_IXW-1:0] ADT_IX_PARAM = 5'h00;
  localparam logic [ADT_IXW-1:0] ADT_IX_AWC0 = 5'h01;
  localparam logic [ADT_IXW-1:0] ADT_IX_AWM0 = 5'h02;
  localparam logic [ADT_IXW-1:0] ADT_IX_AWC1 = 5'h03;
  localparam logic [ADT_IXW-1:0] ADT_IX_AWM1 = 5'h04;
  localparam logic [ADT_IXW-1:0] ADT_IX_ARC0 = 5'h05;
  localparam logic [ADT_IXW-1:0] ADT_IX_ARM0 = 5'h06;
  localparam logic [ADT_IXW-1:0] ADT_IX_ARC1 = 5'h07;
  localparam logic [ADT_IXW-1:0] ADT_IX_ARM1 = 5'h08;
  localparam int ADT_IX_WC0 = 9;
  localparam int ADT_WPAIRS = 3;
  localparam logic [ADT_IXW-1:0] ADT_IX_BC0 = 5'h0F;
  localparam logic [ADT_IXW-1:0] ADT_IX_BM0 = 5'h10;

  // Byte addresses of the storage registers, in index order.
  localparam logic [ADT_AW-1:0] ADT_REG_ADDR [ADT_NREG] = '{
    32'h3FF01500,
    32'h3FF01800, 32'h3FF01808, 32'h3FF01810, 32'h3FF01818,
    32'h3FF01820, 32'h3FF01828, 32'h3FF01830, 32'h3FF01838,
    32'h3FF01840, 32'h3FF01848, 32'h3FF01850, 32'h3FF01858,
    32'h3FF01860, 32'h3FF01868,
    32'h3FF01870, 32'h3FF01878
  };
  localparam logic [ADT_AW-1:0] ADT_ADDR_SWTRIG = 32'h3FF01508;
  localparam logic [ADT_AW-1:0] ADT_ADDR_STATUS = 32'h3FF01510;

  // Parameter register fields.
  localparam int ADT_DELAY_LSB = 0;
  localparam int ADT_DELAY_W = 8;
  localparam int ADT_EXT_LSB = 8;
  localparam int ADT_EXT_W = 8;
  localparam int ADT_CNT_W = 9;

  // Channel word fields.
  localparam int ADT_CH_EN_BIT = 63;
  localparam int ADT_DATA_EN_BIT = 62;
  localparam int ADT_ID_LSB = 0;
  localparam int ADT_ID_W = 16;
  localparam int ADT_AXW = 50;
  localparam int ADT_ADDR_W = 48;
  localparam int ADT_WW = 35;
  localparam int ADT_BW = 20;
  localparam logic [ADT_DW-1:0] ADT_FLD_AX = 64'h0003_FFFF_FFFF_FFFF;
  localparam logic [ADT_DW-1:0] ADT_FLD_ADDR = 64'h0000_FFFF_FFFF_FFFF;
  localparam logic [ADT_DW-1:0] ADT_FLD_B = 64'h0000_0000_000F_FFFF;

  // Status word fields.
  localparam int ADT_ST_PEND_BIT = 0;
  localparam int ADT_ST_FIRED_BIT = 1;
  localparam int ADT_ST_EXT_LSB = 8;
  localparam int ADT_ST_CNT_LSB = 16;

  typedef enum logic [1:0] {
    ADT_IDLE = 2'h1,
    ADT_WAIT = 2'h2
  } adt_state_t;
endpackage

// ### src/adt_trigger.sv
// Bus debug trigger: channel matchers, trigger delay and register slave.
//
// Summary of operation
// - Delay one fires in the cycle after the condition.
// - Delay zero never fires the trigger.
// - Other delays fire value plus two cycles after the condition.
// - Eight enable bits gate external events.
// - Any software trigger write makes a condition.
// - Match is masked observed equals masked value.
// - Write address needs both pairs matching.
// - Mask bit 63 enables write address channel.
// - Bit 62 pairs write address with data.
// - Write address word low field layout.
// - Bit 62 pairs read address with read data.
// - Bit 63 enables read channel; address word.
// - Write data word field layout.
// - Write response word field layout.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
module adt_trigger (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Register port.
  input wire logic [adt_pkg::ADT_AW-1:0] reg_addr,
  input wire logic [adt_pkg::ADT_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [adt_pkg::ADT_DW-1:0] reg_rdata,
  // Observed core channels, same clock as the block.
  input wire logic [adt_pkg::ADT_AXW-1:0] observed_write_addr_signals,
  input wire logic [adt_pkg::ADT_ADDR_W-1:0] observed_awaddr,
  input wire logic [adt_pkg::ADT_AXW-1:0] observed_read_addr_signals,
  input wire logic [adt_pkg::ADT_ADDR_W-1:0] observed_araddr,
  input wire logic [adt_pkg::ADT_WW-1:0] observed_write_data_signals,
  input wire logic [adt_pkg::ADT_BW-1:0] observed_write_resp_signals,
  // Read data condition from the read-data matcher.
  input wire logic read_data_cond_met,
  input wire logic [adt_pkg::ADT_ID_W-1:0] read_data_cond_id,
  // External trigger events, asynchronous.
  input wire logic [adt_pkg::ADT_EXT_W-1:0] ext_trigger_event,
  // Trigger outputs.
  output logic trigger_out,
  output logic trigger_fired
);
  import adt_pkg::*;

  typedef struct packed {
    logic [ADT_NREG-1:0][ADT_DW-1:0] regs;
    adt_state_t state;
    logic [ADT_CNT_W-1:0] cnt;
    logic trig;
    logic fired;
    logic sw;
    logic [ADT_EXT_W-1:0] ext_m;
    logic [ADT_EXT_W-1:0] ext_s;
    logic [ADT_DW-1:0] rdata;
  } adt_st_t;

  adt_st_t st_q;
  adt_st_t st_d;

  // Masked compare restricted to the bits that the mask field covers.
  function automatic logic adt_match(input logic [ADT_DW-1:0] obs,
                                     input logic [ADT_DW-1:0] cond,
                                     input logic [ADT_DW-1:0] mask,
                                     input logic [ADT_DW-1:0] fld);
    logic [ADT_DW-1:0] m;
    m = mask & fld;
    return (obs & m) == (cond & m);
  endfunction

  // Storage index lookup for a byte address.
  function automatic logic [ADT_IXW:0] adt_decode(
      input logic [ADT_AW-1:0] a);
    logic [ADT_IXW:0] r;
    r = '0;
    for (int i = 0; i < ADT_NREG; i++) begin
      if (a == ADT_REG_ADDR[i]) begin
        r = {1'b1, ADT_IXW'(i)};
      end
    end
    return r;
  endfunction

  logic [ADT_DW-1:0] p_reg;
  logic [ADT_DELAY_W-1:0] delay;
  logic [ADT_ID_W-1:0] awid;
  logic [ADT_ID_W-1:0] arid;
  logic [ADT_ID_W-1:0] wid;
  logic aw_hit0;
  logic aw_hit1;
  logic ar_hit0;
  logic ar_hit1;
  logic [ADT_WPAIRS-1:0] w_hit;
  logic w_all;
  logic aw_src;
  logic ar_src;
  logic w_src;
  logic b_src;
  logic ext_src;
  logic chan_src;
  logic cond;
  logic [ADT_IXW:0] wr_dec;
  logic [ADT_IXW:0] rd_dec;

  assign p_reg = st_q.regs[ADT_IX_PARAM];
  assign delay = p_reg[ADT_DELAY_LSB +: ADT_DELAY_W];
  assign awid = observed_write_addr_signals[ADT_ID_LSB +: ADT_ID_W];
  assign arid = observed_read_addr_signals[ADT_ID_LSB +: ADT_ID_W];
  assign wid = observed_write_data_signals[ADT_ID_LSB +: ADT_ID_W];

  // Channel words are presented in register layout, so each compares
  // directly against its stored value after zero extension.
  assign aw_hit0 = adt_match(ADT_DW'(observed_write_addr_signals),
    st_q.regs[ADT_IX_AWC0], st_q.regs[ADT_IX_AWM0], ADT_FLD_AX);
  assign aw_hit1 = adt_match(ADT_DW'(observed_awaddr),
    st_q.regs[ADT_IX_AWC1], st_q.regs[ADT_IX_AWM1], ADT_FLD_ADDR);
  assign ar_hit0 = adt_match(ADT_DW'(observed_read_addr_signals),
    st_q.regs[ADT_IX_ARC0], st_q.regs[ADT_IX_ARM0], ADT_FLD_AX);
  assign ar_hit1 = adt_match(ADT_DW'(observed_araddr),
    st_q.regs[ADT_IX_ARC1], st_q.regs[ADT_IX_ARM1], ADT_FLD_ADDR);

  // All three write data pairs must match together.
  for (genvar k = 0; k < ADT_WPAIRS; k++) begin : g_wpair
    assign w_hit[k] = adt_match(ADT_DW'(observed_write_data_signals),
      st_q.regs[ADT_IX_WC0 + 2 * k], st_q.regs[ADT_IX_WC0 + 2 * k + 1],
      ADT_FLD_AX);
  end
  assign w_all = &w_hit;

  assign aw_src = st_q.regs[ADT_IX_AWM0][ADT_CH_EN_BIT]
    && aw_hit0 && aw_hit1
    && (!st_q.regs[ADT_IX_AWM0][ADT_DATA_EN_BIT]
        || (w_all && wid == awid));
  assign ar_src = st_q.regs[ADT_IX_ARM0][ADT_CH_EN_BIT]
    && ar_hit0 && ar_hit1
    && (!st_q.regs[ADT_IX_ARM0][ADT_DATA_EN_BIT]
        || (read_data_cond_met && read_data_cond_id == arid));
  // Write data alone fires only with its own enable; paired use leaves it
  // clear so that the pairing alone qualifies the data.
  assign w_src = st_q.regs[ADT_IX_WC0 + 1][ADT_CH_EN_BIT] && w_all;
  assign b_src = st_q.regs[ADT_IX_BM0][ADT_CH_EN_BIT]
    && adt_match(ADT_DW'(observed_write_resp_signals),
       st_q.regs[ADT_IX_BC0], st_q.regs[ADT_IX_BM0], ADT_FLD_B);
  assign ext_src = |(st_q.ext_s & p_reg[ADT_EXT_LSB +: ADT_EXT_W]);
  assign chan_src = aw_src || ar_src || w_src || b_src;
  assign cond = chan_src || ext_src || st_q.sw;

  assign wr_dec = adt_decode(reg_addr);
  assign rd_dec = wr_dec;

  always_comb begin
    st_d = st_q;
    st_d.trig = 1'b0;
    // External events are asynchronous and pass two flops first.
    st_d.ext_m = ext_trigger_event;
    st_d.ext_s = st_q.ext_m;
    st_d.sw = reg_wr && reg_addr == ADT_ADDR_SWTRIG;
    if (reg_wr && wr_dec[ADT_IXW]) begin
      st_d.regs[wr_dec[ADT_IXW-1:0]] = reg_wdata;
    end
    st_d.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == ADT_ADDR_STATUS) begin
        st_d.rdata[ADT_ST_PEND_BIT] = st_q.state == ADT_WAIT;
        st_d.rdata[ADT_ST_FIRED_BIT] = st_q.fired;
        st_d.rdata[ADT_ST_EXT_LSB +: ADT_EXT_W] = st_q.ext_s;
        st_d.rdata[ADT_ST_CNT_LSB +: ADT_CNT_W] = st_q.cnt;
      end else if (rd_dec[ADT_IXW]) begin
        st_d.rdata = st_q.regs[rd_dec[ADT_IXW-1:0]];
      end
    end
    // A write to the status word clears the fired flag; a new fire wins.
    if (reg_wr && reg_addr == ADT_ADDR_STATUS) begin
      st_d.fired = 1'b0;
    end
    case (st_q.state)
      ADT_IDLE: begin
        if (cond && delay == ADT_DELAY_W'(1)) begin
          st_d.trig = 1'b1;
        end else if (cond && delay != '0) begin
          st_d.cnt = ADT_CNT_W'(delay) + ADT_CNT_W'(1);
          st_d.state = ADT_WAIT;
        end
      end
      ADT_WAIT: begin
        st_d.cnt = st_q.cnt - ADT_CNT_W'(1);
        if (st_q.cnt == ADT_CNT_W'(1)) begin
          st_d.trig = 1'b1;
          st_d.state = ADT_IDLE;
        end
      end
      default: begin
        st_d.state = ADT_IDLE;
        st_d.cnt = '0;
      end
    endcase
    if (st_d.trig) begin
      st_d.fired = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_q <= '0;
      st_q.state <= ADT_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata = st_q.rdata;
  assign trigger_out = st_q.trig;
  assign trigger_fired = st_q.fired;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic idle;
  assign idle = st_q.state == ADT_IDLE;

  sequence s_sw_write;
    reg_wr && reg_addr == ADT_ADDR_SWTRIG;
  endsequence
  sequence s_sw_fire;
    ##1 (idle && delay == ADT_DELAY_W'(1)) ##1 trigger_out;
  endsequence

  a_zero_delay_silent: assert property (
    idle && delay == '0 |=> !trigger_out)
    else $error("trigger fired with zero delay");
  a_immediate_fire: assert property (
    idle && cond && delay == ADT_DELAY_W'(1) |=> trigger_out)
    else $error("delay one did not fire in the next cycle");
  a_delay_load: assert property (
    idle && cond && delay > ADT_DELAY_W'(1)
    |=> !trigger_out && st_q.cnt == ADT_CNT_W'($past(delay)) + 9'h001)
    else $error("delay counter not loaded with value plus one");
  a_delay_expire: assert property (
    st_q.state == ADT_WAIT && st_q.cnt == ADT_CNT_W'(1)
    |=> trigger_out && idle)
    else $error("delayed trigger missing at count end");
  a_ext_gated: assert property (
    idle && delay == ADT_DELAY_W'(1) && !chan_src && !st_q.sw
    && (st_q.ext_s & p_reg[ADT_EXT_LSB +: ADT_EXT_W]) == '0
    |=> !trigger_out)
    else $error("disabled external event fired the trigger");
  a_sw_write_fires: assert property (
    s_sw_write |-> s_sw_fire or
    ##1 !(idle && delay == ADT_DELAY_W'(1)))
    else $error("software trigger write did not fire");
  a_aw_both_pairs: assert property (
    aw_src |-> aw_hit0 && aw_hit1
    && st_q.regs[ADT_IX_AWM0][ADT_CH_EN_BIT])
    else $error("write address fired without both pairs");
  a_aw_pairing: assert property (
    aw_src && st_q.regs[ADT_IX_AWM0][ADT_DATA_EN_BIT]
    |-> w_all && wid == awid)
    else $error("paired write address fired without data match");
  a_ar_pairing: assert property (
    ar_src && st_q.regs[ADT_IX_ARM0][ADT_DATA_EN_BIT]
    |-> read_data_cond_met && read_data_cond_id == arid)
    else $error("paired read address fired without data match");
  a_param_readback: assert property (
    reg_rd && reg_addr == ADT_REG_ADDR[0] && !reg_wr
    |=> reg_rdata == $past(p_reg))
    else $error("parameter read data wrong");
endmodule
